// file: rtl/input_path_defines.vh
// register offsets, fields, reset values and timing counts for the input path control block
`ifndef INPUT_PATH_DEFINES_VH
`define INPUT_PATH_DEFINES_VH

// register word indices; the byte address on the bus is four times the index
`define ADDR_CONTROL 12'h000
`define ADDR_CANCEL_SRC 12'hF01
`define ADDR_STATUS 12'h002
`define ADDR_PATH_BASE 12'h040
`define ADDR_VOLUME_BASE 12'h080

`define CANCEL_RIGHT_HI 6
`define CANCEL_RIGHT_LO 4
`define CANCEL_LEFT_HI 2
`define CANCEL_LEFT_LO 0
`define CANCEL_RESERVED 3'h7

`define CTRL_UPDATE_BIT 0
`define CTRL_RISE_LO 4
`define CTRL_FALL_LO 8

`define VOL_RESET 8'h80
`define VOL_MAX 8'hBF
`define VOL_MUTE_BIT 8

`define PATH_MODE_BIT 0
`define PATH_ENABLE_BIT 1
`define PATH_PULLDOWN_BIT 2
`define PATH_OSR_LO 4
`define PATH_DLY_L_LO 8
`define PATH_DLY_R_LO 12

`define OSR_MIN 3'h2
`define OSR_MAX 3'h6
`define OSR_CANCEL 3'h5
`define OSR_RESET 3'h4

`define SYS_CLK_KHZ 50000
`define MIC_BASE_KHZ 384
`define MIC_BASE_HALF ((`SYS_CLK_KHZ) / (2 * `MIC_BASE_KHZ))

`endif

// file: rtl/gain_ramp.v
// one channel gain ramp in eighth-decibel steps with mute
`timescale 1ns/1ps
`include "input_path_defines.vh"
module gain_ramp #(
	parameter RATE_W = 4
) (
	input wire hclk,
	input wire hresetn,
	input wire [7:0] target_vol,
	input wire target_mute,
	input wire [RATE_W-1:0] rise_rate,
	input wire [RATE_W-1:0] fall_rate,
	output reg [9:0] gain_r,
	output reg silent_r,
	output reg busy_r
);
	reg [15:0] tick_r;
	wire [9:0] goal = target_mute ? 10'h000 : {target_vol, 2'b00};
	wire up = goal > gain_r;
	wire [RATE_W-1:0] rate = up ? rise_rate : fall_rate;
	wire [15:0] limit = 16'h0001 << rate;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gain_r <= 10'h000;
			tick_r <= 16'h0000;
			silent_r <= 1'b1;
			busy_r <= 1'b0;
		end else begin
			busy_r <= goal != gain_r;
			silent_r <= target_mute && gain_r == 10'h000;
			if (goal == gain_r) begin
				tick_r <= 16'h0000;
			end else if (tick_r + 16'h0001 >= limit) begin
				tick_r <= 16'h0000;
				if (up) begin
					gain_r <= gain_r + 10'h001;
				end else begin
					gain_r <= gain_r - 10'h001;
				end
			end else begin
				tick_r <= tick_r + 16'h0001;
			end
		end
	end
endmodule

// file: rtl/mic_clock_gen.v
// pdm microphone clock divider and half-phase data capture with delay line
`timescale 1ns/1ps
`include "input_path_defines.vh"
module mic_clock_gen #(
	parameter DLY_W = 4
) (
	input wire hclk,
	input wire hresetn,
	input wire run,
	input wire [2:0] osr,
	input wire data_sync,
	input wire [DLY_W-1:0] dly_left,
	input wire [DLY_W-1:0] dly_right,
	output reg clk_r,
	output reg left_bit_r,
	output reg right_bit_r,
	output reg strobe_r
);
	localparam DEPTH = 1 << DLY_W;
	reg [15:0] cnt_r;
	reg [DEPTH-1:0] left_line_r;
	reg [DEPTH-1:0] right_line_r;
	wire [2:0] code = (osr < `OSR_MIN) ? `OSR_MIN : ((osr > `OSR_MAX) ? `OSR_MAX : osr);
	wire [31:0] half_full = `MIC_BASE_HALF >> (code - `OSR_MIN);
	wire [15:0] half = half_full[15:0];
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= 16'h0000;
			clk_r <= 1'b0;
			left_line_r <= {DEPTH{1'b0}};
			right_line_r <= {DEPTH{1'b0}};
			left_bit_r <= 1'b0;
			right_bit_r <= 1'b0;
			strobe_r <= 1'b0;
		end else begin
			strobe_r <= 1'b0;
			if (!run) begin
				cnt_r <= 16'h0000;
				clk_r <= 1'b0;
			end else if (cnt_r + 16'h0001 >= half) begin
				cnt_r <= 16'h0000;
				clk_r <= ~clk_r;
				if (clk_r) begin
					left_line_r <= {left_line_r[DEPTH-2:0], data_sync};
				end else begin
					right_line_r <= {right_line_r[DEPTH-2:0], data_sync};
					left_bit_r <= left_line_r[dly_left];
					right_bit_r <= right_line_r[dly_right];
					strobe_r <= 1'b1;
				end
			end else begin
				cnt_r <= cnt_r + 16'h0001;
			end
		end
	end
endmodule

// file: rtl/input_path_ctrl.v
// volume, ramp, noise-cancel source and pdm microphone control for six stereo input paths
// Contract
// - each channel gain spans -64dB to +31.5dB in 0.5dB steps
// - each path has its own mute, independent of others and volume
// - gain increase or unmute ramps at the rising rate field
// - gain decrease or mute ramps at the falling rate field
// - volume and mute only apply to all paths on update trigger write
// - internal gain moves in 0.125dB steps
// - volume code 00h -64dB, 80h 0dB, BFh +31.5dB, above reserved
// - unity gain maps -6dBFS path level to core full scale
// - right cancel source bits 6:4, 0 none, 1-6 paths, 7 reserved
// - left cancel source bits 2:0, same encoding
// - path chosen as cancel source runs mic clock at 3.072MHz
// - mic clock rate follows each path oversample select
// - separate left and right sample delay per microphone
// - each enabled path in mic mode drives clock pin, data pin input
// - independent data pull-downs, forced off when path disabled
// - oversample code 010 is 384kHz, doubling up to 110
// - data captured at end of each phase, left high, right low
`timescale 1ns/1ps
`include "input_path_defines.vh"
module input_path_ctrl #(
	parameter PATHS = 6,
	parameter RATE_W = 4,
	parameter DLY_W = 4
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire [PATHS-1:0] mic_data_pin,
	output reg [PATHS-1:0] mic_clock_pin,
	output reg [PATHS-1:0] mic_clock_oe,
	output reg [PATHS-1:0] mic_data_pulldown,
	output reg [PATHS-1:0] sample_strobe,
	output reg [2*PATHS-1:0] sample_bits,
	output reg [20*PATHS-1:0] channel_gain,
	output reg [2*PATHS-1:0] channel_silent,
	output reg [2:0] left_cancel_source,
	output reg [2:0] right_cancel_source
);
	reg [RATE_W-1:0] gain_rise_rate_r;
	reg [RATE_W-1:0] gain_fall_rate_r;
	reg [6:0] cancel_r;
	reg [8:0] vol_pend_r [0:2*PATHS-1];
	reg [8:0] vol_live_r [0:2*PATHS-1];
	reg [15:0] path_cfg_r [0:PATHS-1];
	reg [PATHS-1:0] data_meta_r;
	reg [PATHS-1:0] data_sync_r;
	reg wr_pend_r;
	reg [11:0] addr_r;
	wire [2*PATHS-1:0] busy;
	wire [9:0] gain [0:2*PATHS-1];
	wire [2*PATHS-1:0] silent;
	wire [PATHS-1:0] mclk;
	wire [PATHS-1:0] lbit;
	wire [PATHS-1:0] rbit;
	wire [PATHS-1:0] strobe;
	wire take = hsel && hready && htrans[1];
	wire [11:0] rd_index = haddr[13:2];
	wire hit_control = addr_r == `ADDR_CONTROL;
	wire hit_cancel = addr_r == `ADDR_CANCEL_SRC;
	wire [2*PATHS-1:0] hit_volume;
	wire [PATHS-1:0] hit_path;
	wire [2:0] right_field = hwdata[`CANCEL_RIGHT_HI:`CANCEL_RIGHT_LO];
	wire [2:0] left_field = hwdata[`CANCEL_LEFT_HI:`CANCEL_LEFT_LO];
	wire vol_code_ok = hwdata[7:0] <= `VOL_MAX;
	reg [31:0] rdata_nxt;
	integer i;
	integer j;
	integer k;
	integer m;
	integer n;

	// word-index decode of the registered address phase
	genvar h;
	generate
		for (h = 0; h < 2*PATHS; h = h + 1) begin : vol_dec
			localparam [11:0] IDX = `ADDR_VOLUME_BASE + h;
			assign hit_volume[h] = addr_r == IDX;
		end
		for (h = 0; h < PATHS; h = h + 1) begin : path_dec
			localparam [11:0] IDX = `ADDR_PATH_BASE + h;
			assign hit_path[h] = addr_r == IDX;
		end
	endgenerate

	// bus slave: zero wait states, always OKAY
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			addr_r <= 12'h000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (hready) begin
				wr_pend_r <= take && hwrite;
				addr_r <= haddr[13:2];
			end
		end
	end

	// ramp rate fields, rewritten by every control word
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gain_rise_rate_r <= {RATE_W{1'b0}};
			gain_fall_rate_r <= {RATE_W{1'b0}};
		end else if (wr_pend_r && hit_control) begin
			gain_rise_rate_r <= hwdata[`CTRL_RISE_LO +: RATE_W];
			gain_fall_rate_r <= hwdata[`CTRL_FALL_LO +: RATE_W];
		end
	end

	// cancel sources; a reserved code leaves its field unchanged
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cancel_r <= 7'h00;
		end else if (wr_pend_r && hit_cancel) begin
			if (right_field != `CANCEL_RESERVED) begin
				cancel_r[6:4] <= right_field;
			end
			if (left_field != `CANCEL_RESERVED) begin
				cancel_r[2:0] <= left_field;
			end
		end
	end

	// pending volumes; the update trigger copies all of them to live at once
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (i = 0; i < 2*PATHS; i = i + 1) begin
				vol_pend_r[i] <= {1'b1, `VOL_RESET};
				vol_live_r[i] <= {1'b1, `VOL_RESET};
			end
		end else begin
			for (i = 0; i < 2*PATHS; i = i + 1) begin
				if (wr_pend_r && hit_volume[i] && vol_code_ok) begin
					vol_pend_r[i] <= hwdata[8:0];
				end
				if (wr_pend_r && hit_control && hwdata[`CTRL_UPDATE_BIT]) begin
					vol_live_r[i] <= vol_pend_r[i];
				end
			end
		end
	end

	// per-path microphone configuration
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (j = 0; j < PATHS; j = j + 1) begin
				path_cfg_r[j] <= {9'h000, `OSR_RESET, 4'h0};
			end
		end else begin
			for (j = 0; j < PATHS; j = j + 1) begin
				if (wr_pend_r && hit_path[j]) begin
					path_cfg_r[j] <= hwdata[15:0];
				end
			end
		end
	end

	// read data for the word addressed in this address phase
	always @* begin
		rdata_nxt = 32'h00000000;
		if (rd_index == `ADDR_CONTROL) begin
			rdata_nxt[`CTRL_RISE_LO +: RATE_W] = gain_rise_rate_r;
			rdata_nxt[`CTRL_FALL_LO +: RATE_W] = gain_fall_rate_r;
		end
		if (rd_index == `ADDR_CANCEL_SRC) begin
			rdata_nxt[6:0] = cancel_r;
		end
		if (rd_index == `ADDR_STATUS) begin
			rdata_nxt[2*PATHS-1:0] = busy;
			rdata_nxt[16 +: 2*PATHS] = silent;
		end
		for (k = 0; k < 2*PATHS; k = k + 1) begin
			if (rd_index == `ADDR_VOLUME_BASE + k) begin
				rdata_nxt[8:0] = vol_pend_r[k];
			end
		end
		for (k = 0; k < PATHS; k = k + 1) begin
			if (rd_index == `ADDR_PATH_BASE + k) begin
				rdata_nxt[15:0] = path_cfg_r[k];
			end
		end
	end

	// read data stands for the one data-phase cycle
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (take && !hwrite) begin
			hrdata <= rdata_nxt;
		end else begin
			hrdata <= 32'h00000000;
		end
	end

	// two-stage synchroniser on microphone data pins
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_meta_r <= {PATHS{1'b0}};
			data_sync_r <= {PATHS{1'b0}};
		end else begin
			data_meta_r <= mic_data_pin;
			data_sync_r <= data_meta_r;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 2*PATHS; g = g + 1) begin : chan
			gain_ramp #(.RATE_W(RATE_W)) u_ramp (
				.hclk(hclk),
				.hresetn(hresetn),
				.target_vol(vol_live_r[g][7:0]),
				.target_mute(vol_live_r[g][`VOL_MUTE_BIT]),
				.rise_rate(gain_rise_rate_r),
				.fall_rate(gain_fall_rate_r),
				.gain_r(gain[g]),
				.silent_r(silent[g]),
				.busy_r(busy[g])
			);
		end
		for (g = 0; g < PATHS; g = g + 1) begin : path
			wire is_src = cancel_r[2:0] == g + 1 || cancel_r[6:4] == g + 1;
			wire [2:0] osr = is_src ? `OSR_CANCEL : path_cfg_r[g][`PATH_OSR_LO +: 3];
			wire run = path_cfg_r[g][`PATH_ENABLE_BIT] && path_cfg_r[g][`PATH_MODE_BIT];
			mic_clock_gen #(.DLY_W(DLY_W)) u_clk (
				.hclk(hclk),
				.hresetn(hresetn),
				.run(run),
				.osr(osr),
				.data_sync(data_sync_r[g]),
				.dly_left(path_cfg_r[g][`PATH_DLY_L_LO +: DLY_W]),
				.dly_right(path_cfg_r[g][`PATH_DLY_R_LO +: DLY_W]),
				.clk_r(mclk[g]),
				.left_bit_r(lbit[g]),
				.right_bit_r(rbit[g]),
				.strobe_r(strobe[g])
			);
		end
	endgenerate

	// registered microphone link outputs
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mic_clock_pin <= {PATHS{1'b0}};
			mic_clock_oe <= {PATHS{1'b0}};
			mic_data_pulldown <= {PATHS{1'b0}};
			sample_strobe <= {PATHS{1'b0}};
			sample_bits <= {2*PATHS{1'b0}};
		end else begin
			mic_clock_pin <= mclk;
			sample_strobe <= strobe;
			for (m = 0; m < PATHS; m = m + 1) begin
				mic_clock_oe[m] <= path_cfg_r[m][`PATH_MODE_BIT] && path_cfg_r[m][`PATH_ENABLE_BIT];
				mic_data_pulldown[m] <= path_cfg_r[m][`PATH_PULLDOWN_BIT] && path_cfg_r[m][`PATH_ENABLE_BIT];
				sample_bits[2*m] <= lbit[m];
				sample_bits[2*m+1] <= rbit[m];
			end
		end
	end

	// registered gain codes and silence flags
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			channel_gain <= {20*PATHS{1'b0}};
			channel_silent <= {2*PATHS{1'b1}};
		end else begin
			channel_silent <= silent;
			for (n = 0; n < 2*PATHS; n = n + 1) begin
				// gain code in eighth-dB, 200h is unity; core applies fixed 6dB offset
				channel_gain[10*n +: 10] <= gain[n];
			end
		end
	end

	// registered cancel source copies
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			left_cancel_source <= 3'h0;
			right_cancel_source <= 3'h0;
		end else begin
			left_cancel_source <= cancel_r[2:0];
			right_cancel_source <= cancel_r[6:4];
		end
	end
endmodule

// file: sim/input_path_ctrl_asserts.sv
// assertions on the input path control block ports
`timescale 1ns/1ps
module input_path_ctrl_asserts #(
	parameter PATHS = 6
) (
	input wire hclk,
	input wire hresetn,
	input wire [PATHS-1:0] mic_clock_pin,
	input wire [PATHS-1:0] mic_clock_oe,
	input wire [PATHS-1:0] sample_strobe,
	input wire [20*PATHS-1:0] channel_gain,
	input wire [2*PATHS-1:0] channel_silent,
	input wire [2:0] left_cancel_source,
	input wire [2:0] right_cancel_source
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire [9:0] g0 = channel_gain[9:0];
	property p_step;
		$changed(g0) |-> (g0 == $past(g0) + 10'h001) || (g0 == $past(g0) - 10'h001);
	endproperty
	a_step: assert property (p_step) else $error("gain moved more than one step");
	property p_max;
		g0 <= 10'h2FC;
	endproperty
	a_max: assert property (p_max) else $error("gain above top code");
	property p_silent;
		channel_silent[0] |-> g0 == 10'h000;
	endproperty
	a_silent: assert property (p_silent) else $error("silent with gain");
	property p_left;
		left_cancel_source != 3'h7;
	endproperty
	a_left: assert property (p_left) else $error("left source reserved");
	property p_right;
		right_cancel_source != 3'h7;
	endproperty
	a_right: assert property (p_right) else $error("right source reserved");
	property p_clk_oe;
		$rose(mic_clock_pin[0]) |-> mic_clock_oe[0];
	endproperty
	a_clk_oe: assert property (p_clk_oe) else $error("clock without enable");
	property p_half;
		$rose(mic_clock_pin[0]) |=> (mic_clock_pin[0] || !mic_clock_oe[0])[*3];
	endproperty
	a_half: assert property (p_half) else $error("clock high phase too short");
	property p_strobe;
		sample_strobe[0] |=> (!sample_strobe[0])[*3];
	endproperty
	a_strobe: assert property (p_strobe) else $error("strobe too frequent");
endmodule

bind input_path_ctrl input_path_ctrl_asserts #(.PATHS(PATHS)) chk_u (.hclk, .hresetn, .mic_clock_pin,
	.mic_clock_oe, .sample_strobe, .channel_gain, .channel_silent, .left_cancel_source, .right_cancel_source);

// file: sim/pdm_mic_pair.sv
// pair of pdm microphones sharing one data line
`timescale 1ns/1ps
module pdm_mic_pair (
	input wire mclk,
	input wire lval,
	input wire rval,
	output wire dat
);
	// left drives while clock high, right while low, each releases for the other
	assign dat = mclk ? lval : rval;
endmodule

// file: sim/input_path_ctrl_bench.sv
// register and microphone tests for the input path control block
`timescale 1ns/1ps
module input_path_ctrl_bench;
	logic hclk, hresetn, hsel, hwrite;
	logic [31:0] haddr, hwdata, rd;
	logic [1:0] htrans;
	logic [5:0] lv, rv;
	wire hready;
	wire [31:0] hrdata;
	wire [5:0] mdat, mclk, moe, mpd, mstb;
	wire [11:0] sbits, silent;
	wire [119:0] gain;
	wire [2:0] lsrc, rsrc;
	int failures, n_compared, n;
	input_path_ctrl dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hready), .hrdata, .hreadyout(hready), .hresp(), .mic_data_pin(mdat), .mic_clock_pin(mclk),
		.mic_clock_oe(moe), .mic_data_pulldown(mpd), .sample_strobe(mstb), .sample_bits(sbits),
		.channel_gain(gain), .channel_silent(silent), .left_cancel_source(lsrc), .right_cancel_source(rsrc));
	pdm_mic_pair mic_u[5:0] (.mclk(mclk), .lval(lv), .rval(rv), .dat(mdat));
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask
	task rdchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(nm, rd, exp);
	endtask
	task settle();
		repeat (2) @(posedge hclk);
		rd = 32'h1;
		while (rd[11:0] !== 12'h000)
			xfer(1'b0, 32'h008, 32'h0);
	endtask
	task period(output int p);
		realtime t0;
		repeat (2) @(posedge mclk[0]);
		t0 = $realtime;
		@(posedge mclk[0]);
		p = int'(($realtime - t0) / 20.0);
	endtask
	task stop_test();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	initial begin
		#1000000;
		failures++;
		stop_test();
	end
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		lv = 6'h3F;
		rv = 6'h00;
		failures = 0;
		n_compared = 0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdchk("vol0", 32'h200, 32'h180);
		rdchk("path0", 32'h100, 32'h40);
		rdchk("src", 32'h3C04, 32'h0);
		xfer(1'b1, 32'h300, 32'h5A);
		rdchk("unmapped", 32'h300, 32'h0);
		$display("test registers finished");
		xfer(1'b1, 32'h200, 32'h084);
		xfer(1'b1, 32'h204, 32'h07C);
		xfer(1'b1, 32'h208, 32'h0C0);
		chk("gain0 held", gain[9:0], 32'h0);
		rdchk("vol2", 32'h208, 32'h180);
		xfer(1'b1, 32'h000, 32'h001);
		settle();
		chk("gain0", gain[9:0], 32'h210);
		chk("gain1", gain[19:10], 32'h1F0);
		chk("gain2", gain[29:20], 32'h0);
		chk("silent", silent, 32'hFFC);
		xfer(1'b1, 32'h200, 32'h184);
		xfer(1'b1, 32'h000, 32'h101);
		settle();
		chk("mute gain0", gain[9:0], 32'h0);
		chk("mute silent0", silent[0], 32'h1);
		chk("gain1 kept", gain[19:10], 32'h1F0);
		$display("test volume finished");
		for (int i = 0; i < 7; i++) begin
			xfer(1'b1, 32'h3C04, (i << 4) | (6 - i));
			repeat (2) @(posedge hclk);
			chk("right src", rsrc, 32'(i));
			chk("left src", lsrc, 32'(6 - i));
		end
		xfer(1'b1, 32'h3C04, 32'h77);
		repeat (2) @(posedge hclk);
		chk("reserved src", {rsrc, lsrc}, 32'h30);
		$display("test cancel finished");
		for (int o = 2; o < 7; o++) begin
			xfer(1'b1, 32'h100, 32'h7 | (o << 4));
			period(n);
			chk("mic period", n, 2 * (65 >> (o - 2)));
		end
		chk("clock oe", moe, 32'h01);
		chk("pulldown", mpd, 32'h01);
		repeat (3) @(posedge mstb[0]);
		@(posedge hclk);
		chk("mic bits", sbits[1:0], 32'h1);
		xfer(1'b1, 32'h100, 32'h27);
		xfer(1'b1, 32'h3C04, 32'h01);
		period(n);
		chk("cancel period", n, 32'h10);
		xfer(1'b1, 32'h100, 32'h25);
		repeat (2) @(posedge hclk);
		chk("pulldown off", mpd, 32'h0);
		chk("oe off", moe, 32'h0);
		$display("test mic finished");
		stop_test();
	end
endmodule
